// File: inc/prs_defs.vh
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH
`define PRS_ADDR_W 40
`define PRS_NC_BIT 39
`define PRS_MEM_TOP 40'h01FFFFFFFF
`define PRS_CSR_BASE 40'hFFFFF00000
`define PRS_CSR_MASK 40'hFFFFF00000
`define PRS_WRAP_LO 4
`define PRS_BEATS_BLK 3'h4
`define PRS_BEATS_NC 3'h2
`define PRS_CLS_MEM 2'h0
`define PRS_CLS_NC 2'h1
`define PRS_CLS_CSR 2'h2
`define PRS_CLS_BAD 2'h3
`define PRS_CMD_NONE 2'h0
`define PRS_CMD_RDMISS 2'h1
`define PRS_CMD_WRBLK 2'h2
`define PRS_CMD_VICTIM 2'h3
`endif

// File: hdl/prs_shaper.v
`include "prs_defs.vh"

module prs_shaper (
  // clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // read requests from miss merger
  input wire RD_VALID_I,
  input wire [39:0] RD_ADDR_I,
  input wire [3:0] RD_QW_MASK_I,
  input wire RD_IFILL_I,
  input wire MEM_BARRIER_I,
  input wire IO_READ_NO_MERGE_I,
  // write requests from write buffer
  input wire WR_VALID_I,
  input wire [39:0] WR_ADDR_I,
  input wire [7:0] WR_LW_MASK_I,
  input wire WR_BARRIER_I,
  // victim and probe data requests
  input wire VIC_VALID_I,
  input wire [39:0] VIC_ADDR_I,
  input wire PRB_VALID_I,
  input wire [1:0] PRB_START_I,
  // system command port
  input wire CMD_READY_I,
  output wire CMD_VALID_O,
  output reg [1:0] CMD_TYPE_O,
  output reg [39:0] CMD_ADDR_O,
  output reg CMD_BLOCK64_O,
  output reg [3:0] CMD_QW_MASK_O,
  // data beat sequencing
  output reg BEAT_VALID_O,
  output reg [1:0] BEAT_UNIT_O,
  output reg [3:0] BEAT_LW_MASK_O,
  // request status
  output wire RD_READY_O,
  output wire WR_READY_O,
  output wire VIC_READY_O,
  output wire PRB_READY_O,
  output reg INTERNAL_HIT_O,
  output reg FILL_CACHEABLE_O,
  output reg FILL_ALL_VALID_O
);

  localparam ST_IDLE = 2'h0;
  localparam ST_CMD = 2'h1;
  localparam ST_BEAT = 2'h2;

  function [1:0] region;
    input [39:0] a;
    begin
      if ((a & `PRS_CSR_MASK) == `PRS_CSR_BASE)
        region = `PRS_CLS_CSR;
      else if (a[`PRS_NC_BIT])
        region = `PRS_CLS_NC;
      else if (a <= `PRS_MEM_TOP)
        region = `PRS_CLS_MEM;
      else
        region = `PRS_CLS_BAD;
    end
  endfunction

  function [1:0] wrap_unit;
    input [1:0] start;
    input [1:0] idx;
    begin
      wrap_unit = start ^ idx;
    end
  endfunction

  // addresses past the top of memory but below bit 39 act as memory
  function mem_like;
    input [1:0] cls;
    begin
      mem_like = (cls == `PRS_CLS_MEM) || (cls == `PRS_CLS_BAD);
    end
  endfunction

  function [2:0] beats_for;
    input mem;
    begin
      beats_for = mem ? `PRS_BEATS_BLK : `PRS_BEATS_NC;
    end
  endfunction

  // even beats carry the low half of the 32-byte mask
  function [3:0] lw_slice;
    input [7:0] mask;
    input odd;
    begin
      lw_slice = odd ? mask[7:4] : mask[3:0];
    end
  endfunction

  reg [1:0] st_q, st_d;
  reg [1:0] cmd_q;
  reg [39:0] addr_q;
  reg blk_q;
  reg [3:0] qw_q;
  reg [7:0] lw_q;
  reg [1:0] start_q;
  reg [2:0] beats_q;
  reg [2:0] idx_q;
  reg [1:0] last_miss_start_q;
  reg data_out_q;
  reg rd_merge_open_q;
  reg wr_merge_open_q;

  wire [1:0] rd_cls = region(RD_ADDR_I);
  wire [1:0] wr_cls = region(WR_ADDR_I);
  wire idle = (st_q == ST_IDLE);
  // control window hits are absorbed here and never queued
  wire rd_int = (rd_cls == `PRS_CLS_CSR);
  wire wr_int = (wr_cls == `PRS_CLS_CSR);
  wire rd_mem = mem_like(rd_cls);
  wire wr_mem = mem_like(wr_cls);
  // probes first, then victim, then reads, then writes
  assign PRB_READY_O = idle;
  assign VIC_READY_O = idle && !PRB_VALID_I;
  assign RD_READY_O = idle && !PRB_VALID_I && !VIC_VALID_I;
  assign WR_READY_O = RD_READY_O && !RD_VALID_I;
  assign CMD_VALID_O = (st_q == ST_CMD);

  wire take_prb = PRB_VALID_I && PRB_READY_O;
  wire take_vic = VIC_VALID_I && VIC_READY_O;
  wire take_rd = RD_VALID_I && RD_READY_O;
  wire take_wr = WR_VALID_I && WR_READY_O;
  wire beat_last = (idx_q == beats_q - 3'h1);

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (take_prb)
          st_d = ST_BEAT;
        else if (take_vic || (take_wr && !wr_int))
          st_d = ST_CMD;
        else if (take_rd && !rd_int)
          st_d = ST_CMD;
      end
      ST_CMD: begin
        if (CMD_READY_I)
          st_d = data_out_q ? ST_BEAT : ST_IDLE;
      end
      ST_BEAT: begin
        if (beat_last)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // barrier levels are only noted; merging itself is upstream
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_merge_open_q <= 1'b0;
      wr_merge_open_q <= 1'b0;
    end else begin
      rd_merge_open_q <= !(MEM_BARRIER_I || IO_READ_NO_MERGE_I);
      wr_merge_open_q <= !(MEM_BARRIER_I || WR_BARRIER_I);
    end
  end

  // start unit of the latest memory read miss, reused by victims
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      last_miss_start_q <= 2'h0;
    end else if (take_rd && !rd_int && rd_mem) begin
      last_miss_start_q <= RD_ADDR_I[5:4];
    end
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmd_q <= `PRS_CMD_NONE;
      addr_q <= 40'h0000000000;
      blk_q <= 1'b0;
      qw_q <= 4'h0;
      lw_q <= 8'h00;
      start_q <= 2'h0;
      beats_q <= 3'h0;
      idx_q <= 3'h0;
      data_out_q <= 1'b0;
    end else begin
      if (st_q == ST_BEAT)
        idx_q <= beat_last ? 3'h0 : idx_q + 3'h1;
      if (take_prb) begin
        start_q <= PRB_START_I;
        beats_q <= `PRS_BEATS_BLK;
        lw_q <= 8'hFF;
        idx_q <= 3'h0;
      end else if (take_vic) begin
        cmd_q <= `PRS_CMD_VICTIM;
        addr_q <= VIC_ADDR_I;
        blk_q <= 1'b1;
        qw_q <= 4'hF;
        lw_q <= 8'hFF;
        start_q <= last_miss_start_q;
        beats_q <= `PRS_BEATS_BLK;
        data_out_q <= 1'b1;
        idx_q <= 3'h0;
      end else if (take_rd && !rd_int) begin
        cmd_q <= `PRS_CMD_RDMISS;
        addr_q <= RD_ADDR_I;
        data_out_q <= 1'b0;
        if (rd_mem) begin
          blk_q <= 1'b1;
          qw_q <= 4'hF;
        end else begin
          blk_q <= 1'b0;
          qw_q <= RD_IFILL_I ? 4'h0 : RD_QW_MASK_I;
        end
      end else if (take_wr && !wr_int) begin
        cmd_q <= `PRS_CMD_WRBLK;
        addr_q <= WR_ADDR_I;
        blk_q <= wr_mem;
        qw_q <= 4'h0;
        // uncached writes never exceed 32 bytes; blocks go out whole
        lw_q <= wr_mem ? 8'hFF : WR_LW_MASK_I;
        start_q <= 2'h0;
        beats_q <= beats_for(wr_mem);
        data_out_q <= 1'b1;
        idx_q <= 3'h0;
      end
    end
  end

  // command fields, one cycle behind the captured request
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CMD_TYPE_O <= `PRS_CMD_NONE;
      CMD_ADDR_O <= 40'h0000000000;
      CMD_BLOCK64_O <= 1'b0;
      CMD_QW_MASK_O <= 4'h0;
    end else begin
      CMD_TYPE_O <= cmd_q;
      CMD_ADDR_O <= addr_q;
      CMD_BLOCK64_O <= blk_q;
      CMD_QW_MASK_O <= qw_q;
    end
  end

  // data beats, one cycle behind the beat state
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BEAT_VALID_O <= 1'b0;
      BEAT_UNIT_O <= 2'h0;
      BEAT_LW_MASK_O <= 4'h0;
    end else begin
      BEAT_VALID_O <= (st_q == ST_BEAT);
      BEAT_UNIT_O <= wrap_unit(start_q, idx_q[1:0]);
      BEAT_LW_MASK_O <= lw_slice(lw_q, idx_q[0]);
    end
  end

  // absorbed control window accesses
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      INTERNAL_HIT_O <= 1'b0;
    end else begin
      INTERNAL_HIT_O <= (take_rd && rd_int) || (take_wr && wr_int);
    end
  end

  // fill handling of the latest taken read
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FILL_CACHEABLE_O <= 1'b0;
      FILL_ALL_VALID_O <= 1'b0;
    end else if (take_rd) begin
      // bit-39 fills go to registers or icache only
      FILL_CACHEABLE_O <= rd_mem;
      FILL_ALL_VALID_O <= RD_IFILL_I || rd_mem;
    end
  end

  wire unused_ok = rd_merge_open_q ^ wr_merge_open_q;

endmodule // prs_shaper

// File: testbench/prs_monitor.sv
module prs_monitor (
  input wire CLK_I, RST_N_I, RD_VALID_I, RD_IFILL_I, RD_READY_O,
  input wire CMD_VALID_O, CMD_READY_I, CMD_BLOCK64_O, INTERNAL_HIT_O,
  input wire FILL_CACHEABLE_O, FILL_ALL_VALID_O,
  input wire [39:0] RD_ADDR_I, CMD_ADDR_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence tk; RD_VALID_I && RD_READY_O; endsequence
  // fields lag valid by one cycle
  sequence cv; CMD_VALID_O && $past(CMD_VALID_O); endsequence
  sequence csr; tk ##0 RD_ADDR_I[39:20] == 20'hFFFFF; endsequence
  mem_cmd_a: assert property (tk ##0 !RD_ADDR_I[39] |=> CMD_VALID_O)
    else $error("no command");
  nc_size_a: assert property (cv ##0 CMD_ADDR_O[39] |-> !CMD_BLOCK64_O)
    else $error("nc size");
  mem_size_a: assert property (cv ##0 !CMD_ADDR_O[39] |-> CMD_BLOCK64_O)
    else $error("mem size");
  cmd_hold_a: assert property (
    cv ##0 !CMD_READY_I |=> CMD_VALID_O && $stable(CMD_ADDR_O))
    else $error("cmd moved");
  csr_hit_a: assert property (csr |-> ##[1:3] INTERNAL_HIT_O)
    else $error("no hit");
  csr_quiet_a: assert property (csr |=> !CMD_VALID_O [*4])
    else $error("csr cmd");
  fill_nc_a: assert property (
    tk |=> FILL_CACHEABLE_O == !$past(RD_ADDR_I[39])) else $error("fill");
  ifill_a: assert property (tk ##0 RD_IFILL_I |=> FILL_ALL_VALID_O)
    else $error("ifill");
endmodule // prs_monitor
bind prs_shaper prs_monitor prs_monitor_inst (.*);

// File: testbench/prs_sys_model.sv
module prs_sys_model (
  input wire clk_i, rst_n_i, cmd_valid_i, slow_i,
  output logic cmd_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 3'h0;
      cmd_ready_o <= 1'b0;
    end else begin
      // only acks commands, never probes the control window
      cmd_ready_o <= cmd_valid_i && !cmd_ready_o &&
        wait_q > {slow_i, 2'h0};
      wait_q <= cmd_valid_i && !cmd_ready_o ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule // prs_sys_model

// File: testbench/physical_region_request_shaper_tb.sv
`include "prs_defs.vh"
module physical_region_request_shaper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = 0, RST_N_I = 0, RD_VALID_I = 0, RD_IFILL_I = 0;
  logic WR_VALID_I = 0, VIC_VALID_I = 0, PRB_VALID_I = 0, slow = 0;
  logic MEM_BARRIER_I = 0, WR_BARRIER_I = 0, IO_READ_NO_MERGE_I = 0;
  logic CMD_READY_I, CMD_VALID_O, BEAT_VALID_O, CMD_BLOCK64_O, RD_READY_O;
  logic WR_READY_O, VIC_READY_O, PRB_READY_O, INTERNAL_HIT_O;
  logic FILL_CACHEABLE_O, FILL_ALL_VALID_O;
  logic [39:0] RD_ADDR_I = 0, WR_ADDR_I = 0, VIC_ADDR_I = 0, CMD_ADDR_O;
  logic [7:0] WR_LW_MASK_I = 0;
  logic [3:0] RD_QW_MASK_I = 0, CMD_QW_MASK_O, BEAT_LW_MASK_O;
  logic [1:0] PRB_START_I = 0, CMD_TYPE_O, BEAT_UNIT_O;
  int bad_count = 0, comparisons = 0, cyc = 0;
  prs_shaper prs_shaper_inst (.*);
  prs_sys_model prs_sys_model_inst (.clk_i(CLK_I), .rst_n_i(RST_N_I),
    .cmd_valid_i(CMD_VALID_O), .slow_i(slow), .cmd_ready_o(CMD_READY_I));
  initial forever #4 CLK_I = ~CLK_I;
  always @(posedge CLK_I) if (++cyc == 600) begin
    bad_count++;
    stop_test();
  end
  task automatic stop_test();
    $display("checks %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input [63:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // k: ifill, probe, victim, write, read
  task automatic go(input [4:0] k, input [39:0] a, input [7:0] m, input [1:0] s);
    @(posedge CLK_I);
    {PRB_VALID_I, VIC_VALID_I, WR_VALID_I, RD_VALID_I} <= k[3:0];
    {RD_IFILL_I, PRB_START_I, RD_QW_MASK_I, WR_LW_MASK_I} <= {k[4], s, m[3:0], m};
    {RD_ADDR_I, WR_ADDR_I, VIC_ADDR_I} <= {3{a}};
    do @(negedge CLK_I);
    while (({PRB_READY_O, VIC_READY_O, WR_READY_O, RD_READY_O} & k[3:0])
      !== k[3:0]);
    @(posedge CLK_I);
    {PRB_VALID_I, VIC_VALID_I, WR_VALID_I, RD_VALID_I} <= 4'h0;
  endtask
  task automatic cmd(input [1:0] t, input b, input [4:0] m);
    do @(negedge CLK_I);
    while ((CMD_VALID_O & CMD_READY_I) !== 1'b1);
    chk(CMD_TYPE_O, t);
    chk(CMD_BLOCK64_O, b);
    if (m[4]) chk(CMD_QW_MASK_O, m[3:0]);
  endtask
  // m[8] set: check longword masks instead of units
  task automatic beats(input int n, input [7:0] u, input [8:0] m);
    int i;
    i = 0;
    repeat (10) begin
      @(negedge CLK_I);
      if (BEAT_VALID_O === 1'b1) begin
        if (m[8]) chk(BEAT_LW_MASK_O, m[4*i+:4]);
        else chk(BEAT_UNIT_O, u[7-2*i-:2]);
        i++;
      end
    end
    chk(i, n);
  endtask
  task automatic t_rd(input [4:0] k, input [39:0] a, input [3:0] m, input c);
    go(k, a, {4'h0, m}, 2'h0);
    cmd(`PRS_CMD_RDMISS, c, {~c, m});
    chk(FILL_CACHEABLE_O, c);
    if (k[4]) chk(FILL_ALL_VALID_O, 1'b1);
  endtask
  task automatic t_csr();
    logic h;
    h = 1'b0;
    go(5'h01, 40'hFFFFF00010, 8'h01, 2'h0);
    repeat (6) begin
      @(negedge CLK_I);
      h |= INTERNAL_HIT_O;
      chk(CMD_VALID_O, 1'b0);
    end
    chk(h, 1'b1);
  endtask
  task automatic t_wr();
    slow = 1'b1;
    go(5'h02, 40'h8000000020, 8'hA5, 2'h0);
    cmd(`PRS_CMD_WRBLK, 1'b0, 5'h00);
    beats(2, 8'h00, 9'h1A5);
    slow = 1'b0;
  endtask
  task automatic t_wrm();
    go(5'h02, 40'h0000000080, 8'h12, 2'h0);
    cmd(`PRS_CMD_WRBLK, 1'b1, 5'h00);
    beats(4, 8'h1B, 9'h000);
  endtask
  task automatic t_vic();
    go(5'h04, 40'h0000001000, 8'h00, 2'h0);
    cmd(`PRS_CMD_VICTIM, 1'b1, 5'h00);
    beats(4, 8'h4E, 9'h000);
  endtask
  task automatic t_prb();
    logic [1:0] s;
    for (int j = 0; j < 4; j++) begin
      s = j[1:0];
      go(5'h08, 40'h0, 8'h00, s);
      beats(4, {s, s ^ 2'h1, s ^ 2'h2, s ^ 2'h3}, 9'h000);
    end
  endtask
  initial begin
    repeat (20) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    t_rd(5'h01, 40'h01FFFFFFD0, 4'hF, 1'b1);
    t_rd(5'h01, 40'h8000000040, 4'h5, 1'b0);
    t_rd(5'h11, 40'hFFFFEFFFC0, 4'h0, 1'b0);
    t_csr();
    t_wr();
    t_vic();
    t_wrm();
    t_rd(5'h01, 40'h0400000000, 4'h3, 1'b1);
    t_prb();
    stop_test();
  end
endmodule // physical_region_request_shaper_tb
